// ---- include/otac_pkg.sv ----
// Purpose: shared constants and types of the orientation trip-angle block
// Assumes: 12-bit signed axis samples, one g equals OTAC_ONE_G counts
// Notes:   angles are whole degrees, tangents and cosines are scaled by 256
package otac_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] OTAC_IDX_TILT   = 8'h2B;
    localparam logic [7:0] OTAC_IDX_THR    = 8'h2C;
    localparam logic [7:0] OTAC_IDX_STATUS = 8'h30;
    localparam logic [7:0] OTAC_IDX_MASK   = 8'h31;
    localparam logic [7:0] OTAC_IDX_ORIENT = 8'h32;

    localparam logic [7:0] OTAC_TILT_RST   = 8'h44;
    localparam logic [7:0] OTAC_THR_RST    = 8'h84;
    localparam logic [2:0] OTAC_EVT_RST    = 3'h0;

    // field positions
    localparam int OTAC_BKFR_LSB = 6;
    localparam int OTAC_ZLCK_LSB = 0;
    localparam int OTAC_THS_LSB  = 3;
    localparam int OTAC_HYS_LSB  = 0;

    // event bits of the status and mask registers
    localparam int OTAC_EVT_CHANGE = 0;
    localparam int OTAC_EVT_FREEZE = 1;
    localparam int OTAC_EVT_LOCK   = 2;

    localparam logic [11:0] OTAC_ONE_G      = 12'h200;
    localparam logic [11:0] OTAC_FREEZE_LSB = 12'h280;
    localparam logic [6:0]  OTAC_MAX_DEG    = 7'h5A;

    typedef enum logic [1:0] {
        OTAC_PORTRAIT_UP     = 2'h0,
        OTAC_PORTRAIT_DOWN   = 2'h1,
        OTAC_LANDSCAPE_RIGHT = 2'h2,
        OTAC_LANDSCAPE_LEFT  = 2'h3
    } otac_pl_t;

    typedef logic [6:0]  otac_deg_arr_t [32];
    typedef logic [6:0]  otac_hys_arr_t [8];
    typedef logic [7:0]  otac_lck_arr_t [8];
    typedef logic [7:0]  otac_cos_arr_t [4];
    typedef logic [15:0] otac_tan_arr_t [19];

    localparam otac_deg_arr_t OTAC_THR_DEG = '{
        7'h00, 7'h02, 7'h04, 7'h06, 7'h08, 7'h0B, 7'h0D, 7'h10,
        7'h12, 7'h15, 7'h18, 7'h1C, 7'h1F, 7'h22, 7'h26, 7'h29,
        7'h2D, 7'h31, 7'h34, 7'h38, 7'h3B, 7'h3E, 7'h42, 7'h45,
        7'h48, 7'h4A, 7'h4D, 7'h50, 7'h52, 7'h54, 7'h56, 7'h58};
    localparam otac_hys_arr_t OTAC_HYS_DEG = '{
        7'h00, 7'h04, 7'h07, 7'h0B, 7'h0E, 7'h11, 7'h15, 7'h18};
    // tangent of the smallest lockout angle per code
    localparam otac_lck_arr_t OTAC_LCK_TAN = '{
        8'h3E, 8'h4F, 8'h61, 8'h74, 8'h89, 8'hA0, 8'hBB, 8'hDA};
    // cosine of 80, 75, 70 and 65 degrees
    localparam otac_cos_arr_t OTAC_BF_COS = '{8'h2C, 8'h42, 8'h58, 8'h6C};
    // tangent at 5 degree steps, the last entry stands in for 89 degrees
    localparam otac_tan_arr_t OTAC_TAN_5DEG = '{
        16'h0000, 16'h0016, 16'h002D, 16'h0045, 16'h005D, 16'h0077, 16'h0094,
        16'h00B3, 16'h00D7, 16'h0100, 16'h0131, 16'h016E, 16'h01BB, 16'h0225,
        16'h02BF, 16'h03BB, 16'h05AC, 16'h0B6E, 16'h394A};

    typedef struct packed {
        logic               valid;
        logic signed [11:0] x;
        logic signed [11:0] y;
        logic signed [11:0] z;
    } otac_sample_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } otac_bus_t;

endpackage : otac_pkg

// ---- design/otac_tan_lut.sv ----
// Purpose: tangent of a whole-degree angle, scaled by 256
// Assumes: angle at most 90 degrees
// Notes:   linear between 5 degree points; coarse near 90 degrees
`timescale 1ns/1ps
`default_nettype none
module otac_tan_lut (
    input  wire logic [6:0]  angle_deg,
    output logic      [15:0] tan_q8
);
    logic [4:0]  idx;
    logic [2:0]  frac;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [18:0] span;

    always_comb
    begin
        idx  = 5'(angle_deg / 7'h05);
        frac = 3'(angle_deg % 7'h05);
        lo   = otac_pkg::OTAC_TAN_5DEG[idx];
        hi   = (idx >= 5'h12) ? lo : otac_pkg::OTAC_TAN_5DEG[idx + 5'h01];
        span = 19'(hi - lo) * 19'(frac);
        tan_q8 = lo + 16'(span / 19'h00005);
    end
endmodule : otac_tan_lut
`default_nettype wire

// ---- design/otac_orient.sv ----
// Purpose: orientation decision with programmable trip, hysteresis and lockout
// Assumes: sample.valid pulses once per output data sample
// Notes:   decision uses squared magnitudes, no square roots; the only divides are by 5, in the tangent lookup
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module otac_orient (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire otac_pkg::otac_bus_t    bus,
    input  wire otac_pkg::otac_sample_t sample,
    output logic      [7:0]            rdata,
    output logic      [1:0]            pl_orientation_field,
    output logic                       back_front_flag,
    output logic                       irq
);
    typedef struct packed {
        logic [7:0] tilt_cfg;
        logic [7:0] thr_cfg;
        logic [2:0] status;
        logic [2:0] mask;
        logic [1:0] pl;
        logic       bf;
        logic       frozen;
        logic       locked;
        logic [7:0] rdata;
        logic       irq;
    } otac_state_t;

    otac_state_t st_r;
    otac_state_t st_nxt;

    logic [11:0] ax;
    logic [11:0] ay;
    logic [11:0] az;
    logic [23:0] x2;
    logic [23:0] y2;
    logic [23:0] z2;
    logic [25:0] m2;
    logic        over;
    logic [1:0]  bkfr;
    logic [2:0]  zlck;
    logic [4:0]  ths;
    logic [2:0]  hys;
    logic [6:0]  thr_deg;
    logic [6:0]  hys_deg;
    logic [7:0]  up_sum;
    logic [6:0]  up_deg;
    logic [6:0]  dn_deg;
    logic [15:0] tan_up;
    logic [15:0] tan_dn;
    logic [7:0]  cos_bf;
    logic [7:0]  tan_lk;
    logic [41:0] z_lhs;
    logic [41:0] bf_rhs;
    logic [41:0] xy_lhs;
    logic [41:0] lk_rhs;
    logic        go_front;
    logic        go_back;
    logic        lock_now;
    logic [29:0] y_scaled;
    logic [29:0] x_up;
    logic [29:0] x_dn;
    logic        to_portrait;
    logic        to_landscape;
    logic        is_portrait;
    logic [1:0]  pl_new;
    logic        bf_new;
    logic        upd;
    logic [7:0]  idx;
    logic [2:0]  evt;

    always_comb
    begin
        ax = sample.x[11] ? 12'(-sample.x) : 12'(sample.x);
        ay = sample.y[11] ? 12'(-sample.y) : 12'(sample.y);
        az = sample.z[11] ? 12'(-sample.z) : 12'(sample.z);
        x2 = 24'(ax) * 24'(ax);
        y2 = 24'(ay) * 24'(ay);
        z2 = 24'(az) * 24'(az);
        m2 = 26'(x2) + 26'(y2) + 26'(z2);
    end

    assign over = (ax > otac_pkg::OTAC_FREEZE_LSB) || (ay > otac_pkg::OTAC_FREEZE_LSB)
                  || (az > otac_pkg::OTAC_FREEZE_LSB);

    assign bkfr = st_r.tilt_cfg[otac_pkg::OTAC_BKFR_LSB +: 2];
    assign zlck = st_r.tilt_cfg[otac_pkg::OTAC_ZLCK_LSB +: 3];
    assign ths  = st_r.thr_cfg[otac_pkg::OTAC_THS_LSB +: 5];
    assign hys  = st_r.thr_cfg[otac_pkg::OTAC_HYS_LSB +: 3];

    always_comb
    begin
        thr_deg = otac_pkg::OTAC_THR_DEG[ths];
        hys_deg = otac_pkg::OTAC_HYS_DEG[hys];
        up_sum  = 8'(thr_deg) + 8'(hys_deg);
        up_deg  = (up_sum > 8'(otac_pkg::OTAC_MAX_DEG)) ? otac_pkg::OTAC_MAX_DEG
                                                         : up_sum[6:0];
        dn_deg  = (thr_deg > hys_deg) ? 7'(thr_deg - hys_deg) : 7'h00;
    end

    otac_tan_lut u_tan_up (
        .angle_deg (up_deg),
        .tan_q8    (tan_up)
    );

    otac_tan_lut u_tan_dn (
        .angle_deg (dn_deg),
        .tan_q8    (tan_dn)
    );

    // z angle against cos of trip angle
    always_comb
    begin
        cos_bf   = otac_pkg::OTAC_BF_COS[bkfr];
        z_lhs    = {2'h0, z2, 16'h0000};
        bf_rhs   = 42'(16'(cos_bf) * 16'(cos_bf)) * 42'(m2);
        go_front = !sample.z[11] && (sample.z != 12'h000) && (z_lhs > bf_rhs);
        go_back  = sample.z[11] && (z_lhs > bf_rhs);
        bf_new   = go_front ? 1'b0 : (go_back ? 1'b1 : st_r.bf);
    end

    // tilt below lockout angle holds portrait/landscape
    always_comb
    begin
        tan_lk   = otac_pkg::OTAC_LCK_TAN[zlck];
        xy_lhs   = {1'b0, 25'(x2) + 25'(y2), 16'h0000};
        lk_rhs   = 42'(16'(tan_lk) * 16'(tan_lk)) * 42'(z2);
        lock_now = xy_lhs < lk_rhs;
    end

    // hysteresis picks trip by current state
    always_comb
    begin
        y_scaled     = {10'h000, ay, 8'h00};
        x_up         = 30'(ax) * 30'(tan_up);
        x_dn         = 30'(ax) * 30'(tan_dn);
        to_portrait  = y_scaled > x_up;
        to_landscape = y_scaled < x_dn;
        is_portrait  = st_r.pl[1] ? to_portrait : !to_landscape;
    end

    // portrait on y axis, landscape on x axis
    // field encoding of the four orientations
    always_comb
    begin
        if (is_portrait)
            pl_new = sample.y[11] ? otac_pkg::OTAC_PORTRAIT_UP : otac_pkg::OTAC_PORTRAIT_DOWN;
        else
            pl_new = (sample.x[11] || sample.x == 12'h000) ? otac_pkg::OTAC_LANDSCAPE_LEFT
                                                           : otac_pkg::OTAC_LANDSCAPE_RIGHT;
    end

    assign upd = sample.valid && !over;
    assign idx = bus.addr[9:2];

    always_comb
    begin
        st_nxt = st_r;
        evt    = 3'h0;
        if (upd)
        begin
            st_nxt.bf = bf_new;
            if (!lock_now)
                st_nxt.pl = pl_new;
            evt[otac_pkg::OTAC_EVT_CHANGE] = (bf_new != st_r.bf)
                                             || (!lock_now && pl_new != st_r.pl);
        end
        if (sample.valid)
        begin
            st_nxt.frozen = over;
            st_nxt.locked = !over && lock_now;
            evt[otac_pkg::OTAC_EVT_FREEZE] = over && !st_r.frozen;
            evt[otac_pkg::OTAC_EVT_LOCK]   = !over && lock_now && !st_r.locked;
        end
        if (bus.wr)
        begin
            unique case (idx)
                otac_pkg::OTAC_IDX_TILT:   st_nxt.tilt_cfg = bus.wdata;
                otac_pkg::OTAC_IDX_THR:    st_nxt.thr_cfg  = bus.wdata;
                otac_pkg::OTAC_IDX_STATUS: st_nxt.status   = st_r.status & ~bus.wdata[2:0];
                otac_pkg::OTAC_IDX_MASK:   st_nxt.mask     = bus.wdata[2:0];
                default:                   st_nxt.mask     = st_r.mask;
            endcase
        end
        // a new event wins over a clear in the same cycle
        st_nxt.status = st_nxt.status | evt;
        st_nxt.rdata  = 8'h00;
        if (bus.rd)
        begin
            unique case (idx)
                otac_pkg::OTAC_IDX_TILT:   st_nxt.rdata = st_r.tilt_cfg;
                otac_pkg::OTAC_IDX_THR:    st_nxt.rdata = st_r.thr_cfg;
                otac_pkg::OTAC_IDX_STATUS: st_nxt.rdata = {5'h00, st_r.status};
                otac_pkg::OTAC_IDX_MASK:   st_nxt.rdata = {5'h00, st_r.mask};
                otac_pkg::OTAC_IDX_ORIENT: st_nxt.rdata = {3'h0, st_r.locked,
                                                           st_r.frozen, st_r.pl, st_r.bf};
                default:                   st_nxt.rdata = 8'h00;
            endcase
        end
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            st_r          <= '0;
            st_r.tilt_cfg <= otac_pkg::OTAC_TILT_RST;
            st_r.thr_cfg  <= otac_pkg::OTAC_THR_RST;
            st_r.status   <= otac_pkg::OTAC_EVT_RST;
            st_r.mask     <= otac_pkg::OTAC_EVT_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign rdata                = st_r.rdata;
    assign pl_orientation_field = st_r.pl;
    assign back_front_flag      = st_r.bf;
    assign irq                  = st_r.irq;

    // checks
    logic past_rst;

    always_ff @(posedge sys_clk)
    begin
        past_rst <= !resetn;
    end

    property p_bkfr_reset;
        @(posedge sys_clk) past_rst |-> bkfr == 2'h1;
    endproperty
    a_bkfr_reset: assert property (p_bkfr_reset) else $error("bkfr reset wrong");

    property p_zlck_reset;
        @(posedge sys_clk) past_rst |-> zlck == 3'h4 && ths == 5'h10 && hys == 3'h4;
    endproperty
    a_zlck_reset: assert property (p_zlck_reset) else $error("cfg reset wrong");

    property p_thr_write;
        @(posedge sys_clk) disable iff (!resetn)
        bus.wr && idx == otac_pkg::OTAC_IDX_THR |=> st_r.thr_cfg == $past(bus.wdata);
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold write lost");

    property p_front;
        @(posedge sys_clk) disable iff (!resetn)
        upd && go_front |=> !back_front_flag;
    endproperty
    a_front: assert property (p_front) else $error("front not reported");

    property p_back_hold;
        @(posedge sys_clk) disable iff (!resetn)
        upd && !go_front && !go_back |=> $stable(back_front_flag);
    endproperty
    a_back_hold: assert property (p_back_hold) else $error("bf moved in dead band");

    property p_freeze;
        @(posedge sys_clk) disable iff (!resetn)
        sample.valid && over |=> $stable(pl_orientation_field) && $stable(back_front_flag);
    endproperty
    a_freeze: assert property (p_freeze) else $error("decision moved over 1.25 g");

    property p_freeze_evt;
        @(posedge sys_clk) disable iff (!resetn)
        sample.valid && over && !st_r.frozen |=> st_r.status[otac_pkg::OTAC_EVT_FREEZE];
    endproperty
    a_freeze_evt: assert property (p_freeze_evt) else $error("freeze event lost");

    property p_lockout;
        @(posedge sys_clk) disable iff (!resetn)
        upd && lock_now |=> $stable(pl_orientation_field);
    endproperty
    a_lockout: assert property (p_lockout) else $error("pl moved while locked");

    property p_idle;
        @(posedge sys_clk) disable iff (!resetn)
        !sample.valid |=> $stable(pl_orientation_field) && $stable(back_front_flag);
    endproperty
    a_idle: assert property (p_idle) else $error("decision without sample");

    property p_portrait_up;
        @(posedge sys_clk) disable iff (!resetn)
        upd && !lock_now && is_portrait && sample.y[11] |=> pl_orientation_field == 2'h0;
    endproperty
    a_portrait_up: assert property (p_portrait_up) else $error("portrait up code");

    property p_hys_land;
        @(posedge sys_clk) disable iff (!resetn)
        upd && !lock_now && st_r.pl[1] && !to_portrait |=> pl_orientation_field[1];
    endproperty
    a_hys_land: assert property (p_hys_land) else $error("left landscape early");

    property p_trip_order;
        @(posedge sys_clk) disable iff (!resetn)
        1'b1 |-> tan_up >= tan_dn && up_deg >= thr_deg && dn_deg <= thr_deg;
    endproperty
    a_trip_order: assert property (p_trip_order) else $error("trip angles crossed");

    property p_land_side;
        @(posedge sys_clk) disable iff (!resetn)
        upd && !lock_now && !is_portrait && !sample.x[11] && sample.x != 12'h000
        |=> pl_orientation_field == 2'h2;
    endproperty
    a_land_side: assert property (p_land_side) else $error("landscape right code");

    // a cleared mask must silence the line even when an event lands at once
    property p_irq;
        @(posedge sys_clk) disable iff (!resetn)
        bus.wr && idx == otac_pkg::OTAC_IDX_MASK && bus.wdata[2:0] == 3'h0 |=> !irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_rd_data;
        @(posedge sys_clk) disable iff (!resetn)
        bus.rd && idx == otac_pkg::OTAC_IDX_TILT |=> rdata == $past(st_r.tilt_cfg);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data wrong");

    property p_rd_idle;
        @(posedge sys_clk) disable iff (!resetn)
        !bus.rd |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data stood too long");

    c_freeze: cover property (@(posedge sys_clk) disable iff (!resetn) sample.valid && over);
    c_lock: cover property (@(posedge sys_clk) disable iff (!resetn) upd && lock_now);
    c_to_land: cover property (@(posedge sys_clk) disable iff (!resetn)
                               upd && !st_r.pl[1] && to_landscape && !lock_now);
    c_irq: cover property (@(posedge sys_clk) disable iff (!resetn) irq);
endmodule : otac_orient
`default_nettype wire

// ---- verif/tb_otac_orient.sv ----
// Purpose: self-checking bench of the orientation trip-angle block
// Assumes: byte address is the register index times four
// Notes:   test angles sit well clear of trip points, the tangent table is coarse
`timescale 1ns/1ps
`default_nettype none
module tb_otac_orient;
    localparam logic [7:0] tilt = otac_pkg::OTAC_IDX_TILT;
    localparam logic [7:0] thr  = otac_pkg::OTAC_IDX_THR;
    localparam logic [7:0] sts  = otac_pkg::OTAC_IDX_STATUS;
    localparam logic [7:0] msk  = otac_pkg::OTAC_IDX_MASK;
    localparam logic [7:0] ori  = otac_pkg::OTAC_IDX_ORIENT;
    localparam logic [1:0] pl_up    = otac_pkg::OTAC_PORTRAIT_UP;
    localparam logic [1:0] pl_down  = otac_pkg::OTAC_PORTRAIT_DOWN;
    localparam logic [1:0] pl_right = otac_pkg::OTAC_LANDSCAPE_RIGHT;
    localparam logic [1:0] pl_left  = otac_pkg::OTAC_LANDSCAPE_LEFT;

    logic                   sys_clk;
    logic                   resetn;
    otac_pkg::otac_bus_t    bus;
    otac_pkg::otac_sample_t sample;
    logic [7:0]             rdata;
    logic [1:0]             pl;
    logic                   bf;
    logic                   irq;
    int                     mismatches;
    int                     check_count;

    otac_orient i_dut (
        .sys_clk              (sys_clk),
        .resetn               (resetn),
        .bus                  (bus),
        .sample               (sample),
        .rdata                (rdata),
        .pl_orientation_field (pl),
        .back_front_flag      (bf),
        .irq                  (irq)
    );

    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{wr: 1'h1, rd: 1'h0, addr: {idx, 2'h0}, wdata: d};
        @(posedge sys_clk);
        bus <= '0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge sys_clk);
        bus <= '{wr: 1'h0, rd: 1'h1, addr: {idx, 2'h0}, wdata: 8'h00};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        check(rdata, exp);
    endtask : rd

    // one sample, then pl and bf seen one edge later
    task automatic smp(input logic v, input logic signed [11:0] x, input logic signed [11:0] y,
                       input logic signed [11:0] z, input logic [1:0] e_pl, input logic e_bf);
        @(posedge sys_clk);
        sample <= '{valid: v, x: x, y: y, z: z};
        @(posedge sys_clk);
        sample.valid <= 1'h0;
        #1;
        check({6'h00, pl}, {6'h00, e_pl});
        check({7'h00, bf}, {7'h00, e_bf});
    endtask : smp

    // irq moves with status; looked at one edge after the access
    task automatic irq_chk(input logic e);
        @(posedge sys_clk);
        #1;
        check({7'h00, irq}, {7'h00, e});
    endtask : irq_chk

    initial
    begin
        repeat (3000) @(posedge sys_clk);
        mismatches++;
        finish_test();
    end

    initial
    begin
        resetn = 1'h0;
        bus = '0;
        sample = '0;
        mismatches = 0;
        check_count = 0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'h1;
        rd(tilt, 8'h44);
        rd(thr, 8'h84);
        rd(sts, 8'h00);
        rd(msk, 8'h00);
        rd(ori, 8'h00);
        wr(8'h2D, 8'hFF);
        rd(8'h2D, 8'h00);
        // default trips: portrait at 59, landscape at 31
        smp(1'h1, 12'sh000, 12'sh200, 12'sh000, pl_down, 1'h0);
        smp(1'h1, 12'sh200, 12'sh000, 12'sh000, pl_right, 1'h0);
        smp(1'h1, -12'sh200, 12'sh000, 12'sh000, pl_left, 1'h0);
        smp(1'h1, -12'sh12C, -12'sh168, 12'sh000, pl_left, 1'h0);
        smp(1'h1, -12'sh0C8, -12'sh1AE, 12'sh000, pl_up, 1'h0);
        smp(1'h1, -12'sh17C, -12'sh140, 12'sh000, pl_up, 1'h0);
        // hysteresis off: one trip at 45
        wr(thr, 8'h80);
        smp(1'h1, -12'sh17C, -12'sh140, 12'sh000, pl_left, 1'h0);
        smp(1'h1, -12'sh12C, -12'sh168, 12'sh000, pl_up, 1'h0);
        // top threshold code near 88 degrees
        wr(thr, 8'hF8);
        rd(thr, 8'hF8);
        smp(1'h1, -12'sh0BE, -12'sh200, 12'sh000, pl_left, 1'h0);
        wr(thr, 8'h80);
        smp(1'h1, 12'sh000, -12'sh200, 12'sh000, pl_up, 1'h0);
        // threshold 31 with hysteresis 14: trips at 45 and 17
        wr(thr, 8'h64);
        smp(1'h1, -12'sh1BB, -12'sh100, 12'sh000, pl_up, 1'h0);
        smp(1'h1, -12'sh200, -12'sh064, 12'sh000, pl_left, 1'h0);
        // no valid strobe, no decision
        smp(1'h0, 12'sh200, 12'sh000, 12'sh000, pl_left, 1'h0);
        // change event, mask and clear
        wr(sts, 8'h07);
        wr(msk, 8'h01);
        irq_chk(1'h0);
        smp(1'h1, 12'sh200, 12'sh000, 12'sh000, pl_right, 1'h0);
        irq_chk(1'h1);
        rd(sts, 8'h01);
        wr(msk, 8'h00);
        irq_chk(1'h0);
        wr(msk, 8'h01);
        irq_chk(1'h1);
        wr(sts, 8'h01);
        irq_chk(1'h0);
        rd(sts, 8'h00);
        // back/front: steep z locks pl but bf still follows
        smp(1'h1, 12'sh000, -12'sh064, 12'sh1F4, pl_right, 1'h0);
        smp(1'h1, 12'sh000, -12'sh064, -12'sh1F4, pl_right, 1'h1);
        rd(ori, 8'h15);
        rd(sts, 8'h05);
        smp(1'h1, 12'sh000, -12'sh1F4, 12'sh1F4, pl_up, 1'h0);
        // z near 73 degrees: code 11 holds, code 00 flips to back
        wr(tilt, 8'hC4);
        rd(tilt, 8'hC4);
        smp(1'h1, 12'sh000, -12'sh1F4, -12'sh096, pl_up, 1'h0);
        wr(tilt, 8'h04);
        smp(1'h1, 12'sh000, -12'sh1F4, -12'sh096, pl_up, 1'h1);
        // tilt near 24 degrees: largest lockout holds, smallest releases
        wr(tilt, 8'h07);
        smp(1'h1, 12'sh0C8, 12'sh000, -12'sh1C2, pl_up, 1'h1);
        wr(tilt, 8'h00);
        smp(1'h1, 12'sh0C8, 12'sh000, -12'sh1C2, pl_right, 1'h1);
        // freeze just above 1.25 g, none at exactly 1.25 g
        wr(sts, 8'h07);
        smp(1'h1, 12'sh000, 12'sh28A, 12'sh000, pl_right, 1'h1);
        rd(sts, 8'h02);
        smp(1'h1, 12'sh000, 12'sh280, 12'sh000, pl_down, 1'h1);
        rd(sts, 8'h03);
        // the other two axes freeze as well
        smp(1'h1, -12'sh28A, 12'sh000, 12'sh000, pl_down, 1'h1);
        smp(1'h1, 12'sh000, 12'sh000, 12'sh28A, pl_down, 1'h1);
        rd(ori, 8'h0B);
        finish_test();
    end
endmodule : tb_otac_orient
`default_nettype wire
